// [rtl/tsn_sensor.sv]
// serial register access, shutdown and alarm logic of the temperature sensor
// Functional notes
// - temperatures are 13-bit two's complement, 0.0625 degC per step
// - temperature readable anytime; frequent reads stop the value refreshing
// - configuration shutdown bit puts the device in low-power shutdown
// - shutdown halts conversions so alarm outputs ignore temperature
// - serial reads and writes work unchanged during shutdown
// - shutdown takes effect SHDN_DELAY_CYC cycles, one millisecond by default, after the command
// - entering shutdown deasserts window alert and critical alarm outputs
// - with fault queue on, four consecutive faults needed to set flags
// - configuration bit 4 enables the fault queue
// - pointer selects register, resets to temperature, holds last value
// - in interrupt mode any read clears the window alert
// - temperature is read only; configuration and limits are read-write
// - configuration write takes one byte, limit writes take two
// - read with pointer set is address byte then data bytes
// - most significant byte and bit are sent first
// - master may end a read with acknowledge or not-acknowledge
// - short read may hold data low until nine more clocks
// - select codes 0..5: temp, config, hyst, critical, low, high
// - slave address is 10010 followed by two address select pins
// - temperature word holds data in 15..3, status flags in 2..0
// - a read aborts conversion and restarts it when the read ends
`timescale 1ns/100ps
`include "tsn_consts.svh"
module tsn_sensor #(
    parameter int SHDN_DELAY_CYC = `TSN_SHDN_CYC,
    parameter int FQ_DEPTH       = `TSN_FQ_DEPTH
) (
    // clock and reset
    input  wire logic        clk_sys,
    input  wire logic        resetn,
    // serial bus pins
    input  wire logic        scl_in,
    input  wire logic        sda_in,
    output logic             sda_out,
    output logic             sda_oe,
    input  wire logic [1:0]  address_select_pins,
    // converter front end
    input  wire logic [12:0] conv_data,
    input  wire logic        conv_done,
    output logic             conv_enable,
    output logic             conv_abort,
    output logic             shutdown_active,
    // open-drain alarm pins
    output logic             int_out,
    output logic             int_oe,
    output logic             critical_alarm_output,
    output logic             critical_alarm_oe
);

    // =================================================================
    // parameter checks
    initial begin
        if (SHDN_DELAY_CYC < 1 || SHDN_DELAY_CYC > 65535)
            $error("tsn_sensor: SHDN_DELAY_CYC out of range");
        if (FQ_DEPTH < 1 || FQ_DEPTH > 7)
            $error("tsn_sensor: FQ_DEPTH out of range");
    end

    // =================================================================
    // pin synchronisers and edge detection
    logic [3:0] pins_s;
    logic       scl_s;
    logic       sda_s;
    logic [1:0] asel_s;
    logic       scl_d_r;
    logic       sda_d_r;
    logic       scl_rise;
    logic       scl_fall;
    logic       bus_start;
    logic       bus_stop;

    tsn_sync #(
        .W (4)
    ) u_sync (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .d       ({address_select_pins, sda_in, scl_in}),
        .q       (pins_s)
    );

    assign scl_s  = pins_s[0];
    assign sda_s  = pins_s[1];
    assign asel_s = pins_s[3:2];

    // delayed copies for edges
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
        end else begin
            scl_d_r <= scl_s;
            sda_d_r <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_r;
    assign scl_fall  = ~scl_s & scl_d_r;
    assign bus_start = scl_s & scl_d_r & sda_d_r & ~sda_s;
    assign bus_stop  = scl_s & scl_d_r & ~sda_d_r & sda_s;

    // =================================================================
    // register storage
    tsn_pkg::tsn_state_t state_r;
    logic [2:0]  ptr_r;
    logic [7:0]  cfg_r;
    logic [12:0] hyst_r;
    logic [12:0] crit_r;
    logic [12:0] low_r;
    logic [12:0] high_r;
    logic [12:0] temp_r;
    logic [2:0]  flag_w;

    // =================================================================
    // byte engine signals
    logic [3:0]  bit_cnt_r;
    logic [7:0]  shift_r;
    logic [7:0]  tx_r;
    logic        rw_r;
    logic        match_r;
    logic        mack_r;
    logic [1:0]  wr_idx_r;
    logic        rd_idx_r;
    logic [7:0]  msb_hold_r;
    logic        reading_r;
    logic        rd_start;
    logic        wr_commit;
    logic        addr_hit;
    logic [7:0]  rd_byte;
    logic [7:0]  rd_byte_nxt;

    assign addr_hit = (shift_r[7:3] == `TSN_ADDR_HI) && (shift_r[2:1] == asel_s);

    // read byte selection by pointer and byte index
    function automatic logic [7:0] tsn_rd_sel(input logic [2:0] sel, input logic idx,
                                              input logic [15:0] tw, input logic [7:0] cf,
                                              input logic [12:0] hy, input logic [12:0] cr,
                                              input logic [12:0] lo, input logic [12:0] hi);
        logic [15:0] w;
        w = 16'h0000;
        case (sel)
            `TSN_SEL_TEMP: w = tw;
            `TSN_SEL_HYST: w = {hy, 3'h0};
            `TSN_SEL_CRIT: w = {cr, 3'h0};
            `TSN_SEL_LOW:  w = {lo, 3'h0};
            `TSN_SEL_HIGH: w = {hi, 3'h0};
            default:       w = 16'h0000;
        endcase
        if (sel == `TSN_SEL_CFG)
            tsn_rd_sel = cf;
        else if (sel > `TSN_SEL_HIGH)
            tsn_rd_sel = `TSN_UNMAPPED_RD;
        else
            tsn_rd_sel = idx ? w[7:0] : w[15:8];
    endfunction : tsn_rd_sel

    // temperature word layout; rd_byte is always the first byte of a read
    assign rd_byte = tsn_rd_sel(ptr_r, 1'b0, {temp_r, flag_w}, cfg_r,
                                hyst_r, crit_r, low_r, high_r);
    assign rd_byte_nxt = tsn_rd_sel(ptr_r, ~rd_idx_r, {temp_r, flag_w}, cfg_r,
                                    hyst_r, crit_r, low_r, high_r);

    // =================================================================
    // sampling of data on rising clock
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shift_r <= 8'h00;
            mack_r  <= 1'b0;
        end else if (scl_rise) begin
            if (bit_cnt_r < 4'h8)
                shift_r <= {shift_r[6:0], sda_s};
            else
                mack_r <= ~sda_s;
        end
    end

    // =================================================================
    // byte state machine; sda changes only on falling clock
    // no shutdown gating here
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_r   <= tsn_pkg::TSN_IDLE;
            bit_cnt_r <= 4'h0;
            sda_oe    <= 1'b0;
            tx_r      <= 8'h00;
            rw_r      <= 1'b0;
            match_r   <= 1'b0;
            wr_idx_r  <= 2'h0;
            rd_idx_r  <= 1'b0;
        end else if (bus_start) begin
            // repeated start begins a new address phase
            state_r   <= tsn_pkg::TSN_ADDR;
            bit_cnt_r <= 4'hf;  // clock fall closing the start wraps to zero
            sda_oe    <= 1'b0;
        end else if (bus_stop) begin
            state_r   <= tsn_pkg::TSN_IDLE;
            bit_cnt_r <= 4'h0;
            sda_oe    <= 1'b0;
        end else if (scl_fall && state_r != tsn_pkg::TSN_IDLE) begin
            if (bit_cnt_r == 4'h7) begin
                bit_cnt_r <= 4'h8;
                case (state_r)
                    tsn_pkg::TSN_ADDR: begin
                        match_r <= addr_hit;
                        rw_r    <= shift_r[0];
                        sda_oe  <= addr_hit;
                    end
                    tsn_pkg::TSN_PTR:   sda_oe <= 1'b1;
                    tsn_pkg::TSN_WDATA: sda_oe <= 1'b1;
                    default:            sda_oe <= 1'b0;
                endcase
            end else if (bit_cnt_r == 4'h8) begin
                bit_cnt_r <= 4'h0;
                case (state_r)
                    tsn_pkg::TSN_ADDR: begin
                        if (!match_r) begin
                            state_r <= tsn_pkg::TSN_IDLE;
                            sda_oe  <= 1'b0;
                        end else if (rw_r) begin
                            state_r  <= tsn_pkg::TSN_RDATA;
                            rd_idx_r <= 1'b0;
                            tx_r     <= rd_byte;
                            sda_oe   <= ~rd_byte[7];
                        end else begin
                            state_r <= tsn_pkg::TSN_PTR;
                            sda_oe  <= 1'b0;
                        end
                    end
                    tsn_pkg::TSN_PTR: begin
                        state_r  <= tsn_pkg::TSN_WDATA;
                        wr_idx_r <= 2'h0;
                        sda_oe   <= 1'b0;
                    end
                    tsn_pkg::TSN_WDATA: begin
                        if (wr_idx_r != 2'h3)
                            wr_idx_r <= wr_idx_r + 2'h1;
                        sda_oe <= 1'b0;
                    end
                    tsn_pkg::TSN_RDATA: begin
                        if (mack_r) begin
                            rd_idx_r <= ~rd_idx_r;
                            tx_r     <= rd_byte_nxt;
                            sda_oe   <= ~rd_byte_nxt[7];
                        end else begin
                            state_r <= tsn_pkg::TSN_IDLE;
                            sda_oe  <= 1'b0;
                        end
                    end
                    default: sda_oe <= 1'b0;
                endcase
            end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                if (state_r == tsn_pkg::TSN_RDATA) begin
                    tx_r   <= {tx_r[6:0], 1'b0};
                    sda_oe <= ~tx_r[6];
                end
            end
        end
    end

    // open drain data pin: only the enable moves
    assign sda_out = 1'b0;

    // =================================================================
    // read tracking and conversion abort
    assign rd_start = scl_fall && bit_cnt_r == 4'h8 && state_r == tsn_pkg::TSN_ADDR
                      && match_r && rw_r;

    // abort and hold conversions during read
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            reading_r  <= 1'b0;
            conv_abort <= 1'b0;
        end else begin
            conv_abort <= rd_start;
            if (rd_start)
                reading_r <= 1'b1;
            else if (bus_start || bus_stop || state_r != tsn_pkg::TSN_RDATA)
                reading_r <= 1'b0;
        end
    end

    // =================================================================
    // register writes, committed at each data ack
    assign wr_commit = scl_fall && bit_cnt_r == 4'h7 && state_r == tsn_pkg::TSN_WDATA;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            ptr_r      <= `TSN_PTR_RST;
            cfg_r      <= `TSN_CFG_RST;
            hyst_r     <= `TSN_HYST_RST;
            crit_r     <= `TSN_CRIT_RST;
            low_r      <= `TSN_LOW_RST;
            high_r     <= `TSN_HIGH_RST;
            msb_hold_r <= 8'h00;
        end else if (scl_fall && bit_cnt_r == 4'h7 && state_r == tsn_pkg::TSN_PTR) begin
            // pointer latches; low three bits select
            ptr_r <= shift_r[2:0];
        end else if (wr_commit) begin
            // one config byte, two limit bytes
            if (wr_idx_r == 2'h0) begin
                msb_hold_r <= shift_r;
                if (ptr_r == `TSN_SEL_CFG)
                    cfg_r <= shift_r;
            end else if (wr_idx_r == 2'h1) begin
                case (ptr_r)
                    `TSN_SEL_HYST: hyst_r <= {msb_hold_r, shift_r[7:3]};
                    `TSN_SEL_CRIT: crit_r <= {msb_hold_r, shift_r[7:3]};
                    `TSN_SEL_LOW:  low_r  <= {msb_hold_r, shift_r[7:3]};
                    `TSN_SEL_HIGH: high_r <= {msb_hold_r, shift_r[7:3]};
                    default:       ;
                endcase
            end
        end
    end

    // =================================================================
    // shutdown entry delay
    logic [15:0] shdn_cnt_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            shdn_cnt_r      <= 16'h0000;
            shutdown_active <= 1'b0;
        end else if (!cfg_r[`TSN_CFG_SHDN]) begin
            shdn_cnt_r      <= 16'h0000;
            shutdown_active <= 1'b0;
        end else if (!shutdown_active) begin
            if (shdn_cnt_r == 16'(SHDN_DELAY_CYC - 1))
                shutdown_active <= 1'b1;
            else
                shdn_cnt_r <= shdn_cnt_r + 16'h0001;
        end
    end

    // =================================================================
    // conversion acceptance
    logic conv_take;

    // no conversions in shutdown; reads hold off refresh
    assign conv_enable = ~shutdown_active & ~reading_r;
    assign conv_take   = conv_done & conv_enable;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn)
            temp_r <= `TSN_TEMP_RST;
        else if (conv_take)
            temp_r <= conv_data;
    end

    // =================================================================
    // limit comparison with hysteresis and fault queue per flag
    logic [2:0]  fq_need;
    logic [12:0] lim_w [3];

    assign fq_need = cfg_r[`TSN_CFG_FQ] ? 3'(FQ_DEPTH) : 3'h1;
    assign lim_w[`TSN_FLG_LOW]  = low_r;
    assign lim_w[`TSN_FLG_HIGH] = high_r;
    assign lim_w[`TSN_FLG_CRIT] = crit_r;

    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_flag
            logic signed [13:0] t14;
            logic signed [13:0] l14;
            logic signed [13:0] h14;
            logic               trip;
            logic               rel;
            logic [2:0]         cnt_r;
            logic               flag_r;

            assign t14 = {conv_data[12], conv_data};
            assign l14 = {lim_w[gi][12], lim_w[gi]};
            assign h14 = {hyst_r[12], hyst_r};
            if (gi == `TSN_FLG_LOW) begin : g_below
                assign trip = t14 < l14;
                assign rel  = t14 > 14'(l14 + h14);
            end else begin : g_above
                assign trip = t14 > l14;
                assign rel  = t14 < 14'(l14 - h14);
            end

            always_ff @(posedge clk_sys or negedge resetn) begin
                if (!resetn) begin
                    cnt_r  <= 3'h0;
                    flag_r <= 1'b0;
                end else if (conv_take) begin
                    if (trip) begin
                        if (cnt_r != 3'h7)
                            cnt_r <= cnt_r + 3'h1;
                        if (cnt_r + 3'h1 >= fq_need)
                            flag_r <= 1'b1;
                    end else begin
                        cnt_r <= 3'h0;
                        if (rel)
                            flag_r <= 1'b0;
                    end
                end
            end
            assign flag_w[gi] = flag_r;
        end
    endgenerate

    // =================================================================
    // window alert and critical alarm
    logic       upd_r;
    logic [1:0] win_d_r;
    logic       int_act_r;
    logic       win_evt;

    assign win_evt = |(flag_w[1:0] ^ win_d_r);

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            upd_r     <= 1'b0;
            win_d_r   <= 2'h0;
            int_act_r <= 1'b0;
        end else begin
            upd_r   <= conv_take;
            win_d_r <= flag_w[1:0];
            if (shutdown_active)
                int_act_r <= 1'b0;
            else if (upd_r && !cfg_r[`TSN_CFG_EVT])
                int_act_r <= |flag_w[1:0];
            else if (upd_r && win_evt)
                int_act_r <= 1'b1;
            else if (rd_start)
                int_act_r <= 1'b0;
        end
    end

    // open-drain drive: pull low when active with the polarity bit clear, when inactive with it set
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            int_oe            <= 1'b0;
            critical_alarm_oe <= 1'b0;
        end else begin
            int_oe <= cfg_r[`TSN_CFG_IPOL] ? ~int_act_r : int_act_r;
            critical_alarm_oe <= cfg_r[`TSN_CFG_CPOL]
                                 ? ~(flag_w[`TSN_FLG_CRIT] & ~shutdown_active)
                                 : (flag_w[`TSN_FLG_CRIT] & ~shutdown_active);
        end
    end

    assign int_out               = 1'b0;
    assign critical_alarm_output = 1'b0;

endmodule : tsn_sensor

// [rtl/tsn_consts.svh]
// constants for the temperature sensor serial register block
`ifndef TSN_CONSTS_SVH
`define TSN_CONSTS_SVH

// =====================================================================
// slave address and register select codes
`define TSN_ADDR_HI      5'h12
`define TSN_SEL_TEMP     3'h0
`define TSN_SEL_CFG      3'h1
`define TSN_SEL_HYST     3'h2
`define TSN_SEL_CRIT     3'h3
`define TSN_SEL_LOW      3'h4
`define TSN_SEL_HIGH     3'h5
`define TSN_UNMAPPED_RD  8'h00

// =====================================================================
// configuration field positions
`define TSN_CFG_SHDN     0
`define TSN_CFG_EVT      1
`define TSN_CFG_CPOL     2
`define TSN_CFG_IPOL     3
`define TSN_CFG_FQ       4

// =====================================================================
// status flag positions in the low bits of the temperature word
`define TSN_FLG_LOW      0
`define TSN_FLG_HIGH     1
`define TSN_FLG_CRIT     2

// =====================================================================
// reset values (13-bit setpoints, 0.0625 degC per step)
`define TSN_PTR_RST      3'h0
`define TSN_CFG_RST      8'h00
`define TSN_HYST_RST     13'h0020
`define TSN_LOW_RST      13'h00a0
`define TSN_HIGH_RST     13'h0400
`define TSN_CRIT_RST     13'h05a0
`define TSN_TEMP_RST     13'h0000

// =====================================================================
// fault queue and timing
`define TSN_FQ_DEPTH     4
`define TSN_CLK_MHZ      25
`define TSN_SHDN_DELAY_US 1000
`define TSN_SHDN_CYC     (`TSN_SHDN_DELAY_US * `TSN_CLK_MHZ)

`endif

// [rtl/tsn_pkg.sv]
// types shared by the temperature sensor serial register block
package tsn_pkg;

    // =================================================================
    // serial byte engine states
    typedef enum logic [2:0] {
        TSN_IDLE,
        TSN_ADDR,
        TSN_PTR,
        TSN_WDATA,
        TSN_RDATA
    } tsn_state_t;

    // signed 13-bit temperature word
    typedef logic signed [12:0] tsn_temp_t;

endpackage : tsn_pkg

// [rtl/tsn_sync.sv]
// two flip-flop synchroniser for pins entering the system clock domain
`timescale 1ns/100ps
module tsn_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    // data
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    // =================================================================
    // first stage feeds only the second stage
    logic [W-1:0] meta_r;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end

endmodule : tsn_sync

// [testbench/tsn_master.sv]
// serial bus master model for the sensor bench
`timescale 1ns/100ps
module tsn_master (
    // clock and bus lines
    input  wire logic clk_sys,
    input  wire logic sda,
    output logic      scl = 1'b1,
    output logic      sda_low = 1'b0
);
    logic [8:0] i;
    // start (st high) or stop: data moves while clock is high
    task automatic cond(input logic st);
        @(posedge clk_sys) sda_low <= !st;
        repeat (5) @(posedge clk_sys);
        scl <= 1'b1;
        repeat (4) @(posedge clk_sys);
        sda_low <= st;
        repeat (4) @(posedge clk_sys);
        scl <= !st;
    endtask : cond
    // nine bits msb first, 5 cycles low, 3 high
    task automatic xfer(input logic [8:0] o);
        for (int b = 8; b >= 0; b--) begin
            @(posedge clk_sys) sda_low <= !o[b];
            repeat (4) @(posedge clk_sys);
            scl <= 1'b1;
            repeat (3) @(posedge clk_sys);
            i[b] = sda;
            scl <= 1'b0;
        end
    endtask : xfer
    // pointer code 7 skips the pointer phase; q holds nack on writes
    task automatic acc(input logic [6:0] a, input logic rd, input logic [2:0] p,
                       input int n, input logic [15:0] d, output logic [15:0] q);
        q = 16'h0000;
        if (p != 3'h7) begin
            cond(1'b1);
            xfer({a, 2'b01});
            q = {15'h0000, i[0]};
            xfer({5'h00, p, 1'b1});
        end
        for (int k = n; k > 0 && !rd; k--) xfer({d[8*k-1 -: 8], 1'b1});
        // repeated start, read, nack on last byte
        if (rd) begin
            cond(1'b1);
            xfer({a, 2'b11});
        end
        for (int k = n; k > 0 && rd; k--) begin
            xfer({8'hff, k == 1});
            q = {q[7:0], i[8:1]};
        end
        cond(1'b0);
    endtask : acc
endmodule : tsn_master

// [testbench/tsn_sensor_asserts.sv]
// concurrent checks on the sensor ports
`timescale 1ns/100ps
module tsn_sensor_chk (
    // clock, reset and watched pins
    input wire logic clk_sys, resetn, scl_in, sda_oe, conv_done,
    input wire logic conv_enable, conv_abort, shutdown_active,
    input wire logic int_oe, critical_alarm_oe
);
    logic [3:0] since_r;
    // cycles since the last converter result
    always_ff @(posedge clk_sys or negedge resetn)
        if (!resetn) since_r <= 4'hf;
        else if (conv_done) since_r <= 4'h0;
        else if (since_r != 4'hf) since_r <= since_r + 4'h1;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    property p_abort; conv_abort |=> !conv_abort; endproperty
    a_abort: assert property (p_abort) else $error("abort too long");
    property p_abort_en; conv_abort |-> !conv_enable; endproperty
    a_abort_en: assert property (p_abort_en) else $error("convert in read");
    property p_sd_conv; shutdown_active |-> !conv_enable; endproperty
    a_sd_conv: assert property (p_sd_conv) else $error("convert in shutdown");
    property p_sd_alarm; shutdown_active [*4] |-> !int_oe && !critical_alarm_oe; endproperty
    a_sd_alarm: assert property (p_sd_alarm) else $error("alarm in shutdown");
    property p_crit; $rose(critical_alarm_oe) |-> since_r < 4'h5 || $past(shutdown_active, 2);
    endproperty
    a_crit: assert property (p_crit) else $error("alarm without result");
    property p_int; $rose(int_oe) |-> since_r < 4'h5; endproperty
    a_int: assert property (p_int) else $error("alert without result");
    property p_rd_int; conv_abort |-> ##[0:800] !int_oe; endproperty
    a_rd_int: assert property (p_rd_int) else $error("alert kept by read");
    property p_sda; $changed(sda_oe) |-> !scl_in; endproperty
    a_sda: assert property (p_sda) else $error("data moved, clock high");
    c_sd: cover property ($rose(shutdown_active));
    c_int: cover property ($rose(int_oe));
    c_abort: cover property (conv_abort);
endmodule : tsn_sensor_chk

// [testbench/testbench.sv]
// self-checking bench for the sensor serial block
`timescale 1ns/100ps
`include "tsn_consts.svh"
module testbench;
    // pins and bench state
    logic clk_sys = 1'b0, resetn = 1'b0, conv_done = 1'b0, m_low;
    logic [1:0]  address_select_pins = 2'h0;
    logic [12:0] conv_data = 13'h0000;
    logic scl_in, sda_out, sda_oe, conv_enable, conv_abort, shutdown_active;
    logic int_out, int_oe, critical_alarm_output, critical_alarm_oe;
    logic [15:0] q, d;
    logic [6:0]  adr;
    logic [15:0] rst_v [1:5] = '{16'h0000, 16'h0100, 16'h2d00, 16'h0500, 16'h2000};
    int error_cnt = 0, compares = 0, seed = 23;
    wire logic sda_in = !(m_low || sda_oe);
    always #20 clk_sys = ~clk_sys;
    tsn_sensor #(.SHDN_DELAY_CYC(8), .FQ_DEPTH(4)) dut (.*);
    tsn_master m (.clk_sys, .sda(sda_in), .scl(scl_in), .sda_low(m_low));
    task automatic chk(input string s, input logic [15:0] e, g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic finish_test;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // one converter result, then settle
    task automatic cv(input logic [12:0] v);
        @(posedge clk_sys) conv_data <= v;
        conv_done <= 1'b1;
        @(posedge clk_sys) conv_done <= 1'b0;
        repeat (6) @(posedge clk_sys);
    endtask : cv
    // read through a pointer write and compare
    task automatic rr(input logic [2:0] p, input int n, input logic [15:0] e, input string s);
        m.acc(adr, 1'b1, p, n, 16'h0000, q);
        chk(s, e, q);
    endtask : rr
    // hang guard
    initial begin
        repeat (60000) @(posedge clk_sys);
        error_cnt++;
        finish_test();
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        resetn <= 1'b1;
        address_select_pins <= 2'($random(seed));
        repeat (4) @(posedge clk_sys);
        adr = {`TSN_ADDR_HI, address_select_pins};
        m.acc(adr, 1'b1, 3'h7, 2, 16'h0000, q);
        chk("ptr reset", 16'h0000, q);
        for (int r = 1; r < 6; r++) rr(3'(r), r == 1 ? 1 : 2, rst_v[r], "reset");
        cv(13'h0190);
        rr(`TSN_SEL_TEMP, 2, 16'h0c80, "temp");
        cv(13'h1fff);
        rr(`TSN_SEL_TEMP, 2, 16'hfff9, "temp");
        cv(13'h0820);
        chk("int", 16'h0001, int_oe);
        rr(`TSN_SEL_TEMP, 2, 16'h4106, "temp");
        chk("int read", 16'h0000, int_oe);
        m.acc(adr, 1'b1, 3'h7, 2, 16'h0000, q);
        chk("ptr hold", 16'h4106, q);
        chk("crit", 16'h0001, critical_alarm_oe);
        $display("test format done");
        m.acc(adr, 1'b0, `TSN_SEL_CFG, 1, 16'h0001, q);
        for (int n = 0; n < 40 && shutdown_active !== 1'b1; n++) @(posedge clk_sys);
        chk("shutdown", 16'h0001, shutdown_active);
        chk("crit sd", 16'h0000, critical_alarm_oe);
        cv(13'h0190);
        m.acc(adr, 1'b1, `TSN_SEL_TEMP, 2, 16'h0000, q);
        chk("temp sd", 16'h0820, q[15:3]);
        m.acc(adr, 1'b0, `TSN_SEL_CFG, 1, 16'h0000, q);
        cv(13'h0190);
        rr(`TSN_SEL_TEMP, 2, 16'h0c80, "temp run");
        // event mode: a read clears the alert until the flags change again
        m.acc(adr, 1'b0, `TSN_SEL_CFG, 1, 16'h0002, q);
        for (int k = 0; k < 2; k++) begin
            cv(13'h1fff);
            chk("event", 16'(k == 0), int_oe);
            rr(`TSN_SEL_TEMP, 2, 16'hfff9, "temp evt");
        end
        m.acc(adr, 1'b0, `TSN_SEL_CFG, 1, 16'h0010, q);
        for (int k = 1; k < 5; k++) begin
            cv(13'h0820);
            chk("queue", 16'(k == 4), int_oe);
        end
        $display("test shutdown done");
        for (int r = 2; r < 6; r++) begin
            d = $random(seed);
            m.acc(adr, 1'b0, 3'(r), 2, d, q);
            rr(3'(r), 2, d & 16'hfff8, "limit");
        end
        m.acc(adr, 1'b0, `TSN_SEL_TEMP, 2, 16'h5555, q);
        rr(`TSN_SEL_TEMP, 2, 16'h4106, "temp ro");
        rr(3'h6, 1, `TSN_UNMAPPED_RD, "unmapped");
        m.acc(adr ^ 7'h01, 1'b0, `TSN_SEL_CFG, 1, 16'h0000, q);
        chk("nack", 16'h0001, q);
        rr(`TSN_SEL_CFG, 1, 16'h0010, "cfg");
        $display("test access done");
        finish_test();
    end
endmodule : testbench
bind tsn_sensor tsn_sensor_chk u_chk (.*);
